/* shared/redriver_pkg.sv */
// shared constants and types for the redriver link power and equalization control
`default_nettype none
package redriver_pkg;

	localparam int unsigned CLK_HZ = 40_000_000;

	// timing figures in their own units
	localparam int unsigned IDLE_ENTRY_NS   = 10;
	localparam int unsigned U1_EXIT_NS      = 1;
	localparam int unsigned U2U3_EXIT_US    = 10;
	localparam int unsigned RXDET_INTVL_MS  = 12;
	localparam int unsigned AEQ_FULL_US     = 400;
	localparam int unsigned AEQ_FAST_US     = 60;
	localparam int unsigned CFG_HOLD_US     = 500;

	// cycle counts; all times round down, at least one cycle
	function automatic int unsigned floor_cyc(input longint unsigned num, input longint unsigned den);
		longint unsigned c;
		c = (num * CLK_HZ) / den;
		return (c < 1) ? 1 : int'(c);
	endfunction

	localparam int unsigned IDLE_ENTRY_CYC  = floor_cyc(IDLE_ENTRY_NS, 1_000_000_000);
	localparam int unsigned U1_EXIT_CYC     = floor_cyc(U1_EXIT_NS, 1_000_000_000);
	localparam int unsigned U2U3_EXIT_CYC   = floor_cyc(U2U3_EXIT_US, 1_000_000);
	localparam int unsigned RXDET_INTVL_CYC = floor_cyc(RXDET_INTVL_MS, 1_000);
	localparam int unsigned AEQ_FULL_CYC    = floor_cyc(AEQ_FULL_US, 1_000_000);
	localparam int unsigned AEQ_FAST_CYC    = floor_cyc(AEQ_FAST_US, 1_000_000);
	localparam int unsigned CFG_HOLD_CYC    = floor_cyc(CFG_HOLD_US, 1_000_000);

	// four-level strap codes
	localparam logic [1:0] LVL_STRONG_LOW = 2'h0;
	localparam logic [1:0] LVL_WEAK_LOW   = 2'h1;
	localparam logic [1:0] LVL_FLOAT      = 2'h2;
	localparam logic [1:0] LVL_HIGH       = 2'h3;

	// equalization modes
	localparam logic [1:0] EQ_FIXED = 2'h0;
	localparam logic [1:0] EQ_FAST  = 2'h1;
	localparam logic [1:0] EQ_FULL  = 2'h2;

	// reset values
	localparam logic [3:0] EQ_SETTING_RST = 4'h0;
	localparam logic [1:0] EQ_MODE_RST    = 2'h0;

	// link power state reported by the link monitor
	localparam logic [2:0] LINK_U0   = 3'h0;
	localparam logic [2:0] LINK_U1   = 3'h1;
	localparam logic [2:0] LINK_U2   = 3'h2;
	localparam logic [2:0] LINK_U3   = 3'h3;
	localparam logic [2:0] LINK_DISC = 3'h4;

	typedef enum logic [6:0] {
		ST_DISABLED = 7'h01,
		ST_DISC     = 7'h02,
		ST_U0       = 7'h04,
		ST_U1       = 7'h08,
		ST_U2       = 7'h10,
		ST_U3       = 7'h20,
		ST_WAKE     = 7'h40
	} pwr_state_e;

	// sampled strap set
	typedef struct packed {
		logic [1:0] op_mode;
		logic [1:0] conn_eq_hi;
		logic [1:0] conn_eq_lo;
		logic [1:0] host_eq_hi;
		logic [1:0] host_eq_lo;
		logic [1:0] eq_cfg;
		logic [1:0] aeq_cfg;
	} straps_s;

	// serially written configuration
	typedef struct packed {
		logic       use_regs;
		logic [3:0] conn_eq_lane1;
		logic [3:0] conn_eq_lane2;
		logic [3:0] host_eq_lane1;
		logic [3:0] host_eq_lane2;
		logic [1:0] conn_eq_mode;
		logic       limited_en;
		logic       preshoot_enable;
		logic [1:0] preshoot_level;
		logic       deemphasis_enable;
		logic [1:0] deemphasis_level;
	} cfg_regs_s;

	// transmitter shaping toward the host side
	typedef struct packed {
		logic       limited;
		logic       preshoot_enable;
		logic [1:0] preshoot_level;
		logic       deemphasis_enable;
		logic [1:0] deemphasis_level;
	} tx_shape_s;

endpackage
`default_nettype wire

/* rtl/adaptive_eq_timer.sv */
// per-lane adaptive equalization settle timer and choice
`timescale 1ns/1ps
`default_nettype none
module adaptive_eq_timer #(
	parameter int unsigned FULL_CYC = redriver_pkg::AEQ_FULL_CYC,
	parameter int unsigned FAST_CYC = redriver_pkg::AEQ_FAST_CYC
) (
	// clock and reset
	input  wire logic       ref_clk,
	input  wire logic       rst_n,
	// control
	input  wire logic       start,
	input  wire logic [1:0] mode,
	input  wire logic [3:0] fixed_setting,
	input  wire logic [3:0] analog_best,
	input  wire logic       long_channel,
	// result
	output logic [3:0]      setting,
	output logic            done
);
	localparam int unsigned CW = $clog2(FULL_CYC + 1);
	localparam logic [3:0] FAST_SHORT = 4'h3;
	localparam logic [3:0] FAST_LONG  = 4'h9;

	logic [CW-1:0] cnt_q;
	logic          busy_q;

	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			cnt_q   <= '0;
			busy_q  <= 1'b0;
			done    <= 1'b0;
			setting <= redriver_pkg::EQ_SETTING_RST;
		end
		else if (start)
		begin
			busy_q  <= (mode != redriver_pkg::EQ_FIXED);
			done    <= (mode == redriver_pkg::EQ_FIXED);
			setting <= fixed_setting;
			cnt_q   <= (mode == redriver_pkg::EQ_FULL) ? CW'(FULL_CYC - 1) : CW'(FAST_CYC - 1);
		end
		else if (busy_q)
		begin
			if (cnt_q == '0)
			begin
				busy_q  <= 1'b0;
				done    <= 1'b1;
				setting <= (mode == redriver_pkg::EQ_FULL) ? analog_best : (long_channel ? FAST_LONG : FAST_SHORT);
			end
			else
				cnt_q <= cnt_q - 1'b1;
		end
	end
endmodule
`default_nettype wire

/* rtl/redriver_ctrl.sv */
// redriver link power and equalization control
// Operation
// - supports 10 and 5 Gbps plus Disconnect, U1, U2, U3 states.
// - outputs enter electrical idle within 10 ns of leaving U0.
// - U1 exit forwards LFPS within 1 ns of idle break.
// - U2/U3 exit forwards LFPS about 10 us after idle break.
// - receiver detection repeats at most every 12 ms while disconnected.
// - full adaptive equalization settles within 400 us.
// - fast adaptive equalization settles within 60 us.
// - detect one or two lanes; power down the unused lane.
// - sixteen equalization settings per receiver, from straps or registers.
// - connector receivers: fixed, fast or full adaptive, by straps or registers.
// - host-side receivers use fixed equalization only.
// - host-to-connector path is always linear.
// - connector-to-host path linear unless a register enables limited.
// - limited mode offers four pre-shoot and four de-emphasis levels.
// - straps sampled after enable rises, then pull resistors released.
// - each strap resolves to strong low, weak low, floating or strong high.
`timescale 1ns/1ps
`default_nettype none
module redriver_ctrl #(
	parameter int unsigned RXDET_CYC = redriver_pkg::RXDET_INTVL_CYC,
	parameter int unsigned HOLD_CYC  = redriver_pkg::CFG_HOLD_CYC,
	parameter int unsigned WAKE_CYC  = redriver_pkg::U2U3_EXIT_CYC
) (
	// clock and reset
	input  wire logic                    ref_clk,
	input  wire logic                    rst_n,
	// enable and straps
	input  wire logic                    enable,
	input  wire redriver_pkg::straps_s   straps,
	output logic                         strap_pulls_on,
	// register configuration
	input  wire redriver_pkg::cfg_regs_s cfg_regs,
	// link monitor
	input  wire logic [2:0]              link_state,
	input  wire logic                    idle_break,
	input  wire logic                    far_end_present,
	input  wire logic                    lane2_active,
	input  wire logic                    gen2_rate,
	input  wire logic [3:0]              analog_best_lane1,
	input  wire logic [3:0]              analog_best_lane2,
	input  wire logic                    long_channel_lane1,
	input  wire logic                    long_channel_lane2,
	// path control
	output logic                         tx_idle,
	output logic                         lfps_forward,
	output logic                         rx_detect_pulse,
	output logic                         lane1_power,
	output logic                         lane2_power,
	output logic                         gen2_mode,
	output logic [3:0]                   connector_eq_lane1,
	output logic [3:0]                   connector_eq_lane2,
	output logic [3:0]                   host_side_eq_lane1,
	output logic [3:0]                   host_side_eq_lane2,
	output logic [1:0]                   connector_eq_mode,
	output logic                         eq_settled,
	output logic                         host_to_conn_linear,
	output redriver_pkg::tx_shape_s      host_side_tx_shape,
	output redriver_pkg::pwr_state_e     power_state
);
	localparam int unsigned RW = $clog2(RXDET_CYC + 1);
	localparam int unsigned HW = $clog2(HOLD_CYC + 1);
	localparam int unsigned WW = $clog2(WAKE_CYC + 1);

	// two four-level straps form one 4-bit setting
	function automatic logic [3:0] strap_pair(input logic [1:0] hi, input logic [1:0] lo);
		return {hi, lo};
	endfunction

	redriver_pkg::straps_s     straps_q;
	redriver_pkg::pwr_state_e  state_q;
	logic                      en_q;
	logic                      sampled_q;
	logic [HW-1:0]             hold_q;
	logic [RW-1:0]             rxdet_q;
	logic [WW-1:0]             wake_q;
	logic                      aeq_start_q;
	logic [1:0]                eq_mode_d;
	logic [3:0]                conn_fixed1_d;
	logic [3:0]                conn_fixed2_d;
	logic [3:0]                aeq_set1;
	logic [3:0]                aeq_set2;
	logic                      aeq_done1;
	logic                      aeq_done2;
	logic                      enable_rise;

	assign enable_rise = enable & ~en_q;

	// strap capture after enable rise, then pulls released
	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			en_q           <= 1'b0;
			sampled_q      <= 1'b0;
			hold_q         <= '0;
			straps_q       <= '0;
			strap_pulls_on <= 1'b1;
		end
		else
		begin
			en_q <= enable;
			if (!enable)
			begin
				sampled_q      <= 1'b0;
				strap_pulls_on <= 1'b1;
			end
			else if (enable_rise)
				hold_q <= HW'(HOLD_CYC - 1);
			else if (!sampled_q)
			begin
				if (hold_q == '0)
				begin
					straps_q       <= straps;
					sampled_q      <= 1'b1;
					strap_pulls_on <= 1'b0;
				end
				else
					hold_q <= hold_q - 1'b1;
			end
		end
	end

	// equalization source selection
	always_comb
	begin
		if (cfg_regs.use_regs)
		begin
			eq_mode_d     = cfg_regs.conn_eq_mode;
			conn_fixed1_d = cfg_regs.conn_eq_lane1;
			conn_fixed2_d = cfg_regs.conn_eq_lane2;
		end
		else
		begin
			eq_mode_d     = straps_q.aeq_cfg;
			conn_fixed1_d = strap_pair(straps_q.conn_eq_hi, straps_q.conn_eq_lo);
			conn_fixed2_d = conn_fixed1_d;
		end
		if (eq_mode_d == 2'h3)
			eq_mode_d = redriver_pkg::EQ_FIXED;
	end

	// link power state tracking
	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			state_q     <= redriver_pkg::ST_DISABLED;
			tx_idle     <= 1'b1;
			lfps_forward <= 1'b0;
			wake_q      <= '0;
			aeq_start_q <= 1'b0;
		end
		else
		begin
			aeq_start_q <= 1'b0;
			if (!enable || !sampled_q)
			begin
				state_q      <= redriver_pkg::ST_DISABLED;
				tx_idle      <= 1'b1;
				lfps_forward <= 1'b0;
			end
			else
			begin
				unique case (state_q)
					redriver_pkg::ST_DISABLED:
						state_q <= redriver_pkg::ST_DISC;
					redriver_pkg::ST_DISC:
						if (far_end_present)
						begin
							state_q     <= redriver_pkg::ST_U0;
							tx_idle     <= 1'b0;
							aeq_start_q <= 1'b1;
						end
					redriver_pkg::ST_U0:
					begin
						if (link_state != redriver_pkg::LINK_U0)
							tx_idle <= 1'b1;
						unique case (link_state)
							redriver_pkg::LINK_U1:   state_q <= redriver_pkg::ST_U1;
							redriver_pkg::LINK_U2:   state_q <= redriver_pkg::ST_U2;
							redriver_pkg::LINK_U3:   state_q <= redriver_pkg::ST_U3;
							redriver_pkg::LINK_DISC: state_q <= redriver_pkg::ST_DISC;
							default:                 state_q <= redriver_pkg::ST_U0;
						endcase
					end
					redriver_pkg::ST_U1:
						if (idle_break)
						begin
							state_q      <= redriver_pkg::ST_U0;
							tx_idle      <= 1'b0;
							lfps_forward <= 1'b1;
						end
					redriver_pkg::ST_U2, redriver_pkg::ST_U3:
						if (link_state == redriver_pkg::LINK_DISC)
							state_q <= redriver_pkg::ST_DISC;
						else if (idle_break)
						begin
							state_q <= redriver_pkg::ST_WAKE;
							wake_q  <= WW'(WAKE_CYC - 1);
						end
					redriver_pkg::ST_WAKE:
						if (wake_q == '0)
						begin
							state_q      <= redriver_pkg::ST_U0;
							tx_idle      <= 1'b0;
							lfps_forward <= 1'b1;
						end
						else
							wake_q <= wake_q - 1'b1;
				endcase
				if (state_q == redriver_pkg::ST_U0 && link_state == redriver_pkg::LINK_U0 && !idle_break)
					lfps_forward <= 1'b0;
			end
		end
	end

	// receiver detection polling while disconnected
	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			rxdet_q         <= '0;
			rx_detect_pulse <= 1'b0;
		end
		else if (state_q != redriver_pkg::ST_DISC)
		begin
			rxdet_q         <= '0;
			rx_detect_pulse <= 1'b0;
		end
		else
		begin
			rx_detect_pulse <= (rxdet_q == '0);
			rxdet_q <= (rxdet_q == '0) ? RW'(RXDET_CYC - 1) : rxdet_q - 1'b1;
		end
	end

	adaptive_eq_timer u_aeq1 (
		.ref_clk       (ref_clk),
		.rst_n         (rst_n),
		.start         (aeq_start_q),
		.mode          (eq_mode_d),
		.fixed_setting (conn_fixed1_d),
		.analog_best   (analog_best_lane1),
		.long_channel  (long_channel_lane1),
		.setting       (aeq_set1),
		.done          (aeq_done1)
	);

	adaptive_eq_timer u_aeq2 (
		.ref_clk       (ref_clk),
		.rst_n         (rst_n),
		.start         (aeq_start_q),
		.mode          (eq_mode_d),
		.fixed_setting (conn_fixed2_d),
		.analog_best   (analog_best_lane2),
		.long_channel  (long_channel_lane2),
		.setting       (aeq_set2),
		.done          (aeq_done2)
	);

	// equalization, lane power and transmitter shaping outputs
	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			connector_eq_lane1  <= redriver_pkg::EQ_SETTING_RST;
			connector_eq_lane2  <= redriver_pkg::EQ_SETTING_RST;
			host_side_eq_lane1  <= redriver_pkg::EQ_SETTING_RST;
			host_side_eq_lane2  <= redriver_pkg::EQ_SETTING_RST;
			connector_eq_mode   <= redriver_pkg::EQ_MODE_RST;
			eq_settled          <= 1'b0;
			lane1_power         <= 1'b0;
			lane2_power         <= 1'b0;
			gen2_mode           <= 1'b0;
			host_to_conn_linear <= 1'b1;
			host_side_tx_shape  <= '0;
			power_state         <= redriver_pkg::ST_DISABLED;
		end
		else
		begin
			power_state         <= state_q;
			gen2_mode           <= gen2_rate;
			connector_eq_mode   <= eq_mode_d;
			connector_eq_lane1  <= (eq_mode_d == redriver_pkg::EQ_FIXED) ? conn_fixed1_d : aeq_set1;
			connector_eq_lane2  <= (eq_mode_d == redriver_pkg::EQ_FIXED) ? conn_fixed2_d : aeq_set2;
			eq_settled          <= aeq_done1 & aeq_done2;
			host_side_eq_lane1  <= cfg_regs.use_regs ? cfg_regs.host_eq_lane1
			                       : strap_pair(straps_q.host_eq_hi, straps_q.host_eq_lo);
			host_side_eq_lane2  <= cfg_regs.use_regs ? cfg_regs.host_eq_lane2
			                       : strap_pair(straps_q.host_eq_hi, straps_q.host_eq_lo);
			host_to_conn_linear <= 1'b1;
			host_side_tx_shape.limited           <= cfg_regs.use_regs & cfg_regs.limited_en;
			host_side_tx_shape.preshoot_enable   <= cfg_regs.use_regs & cfg_regs.limited_en & cfg_regs.preshoot_enable;
			host_side_tx_shape.preshoot_level    <= cfg_regs.preshoot_level;
			host_side_tx_shape.deemphasis_enable <= cfg_regs.use_regs & cfg_regs.limited_en & cfg_regs.deemphasis_enable;
			host_side_tx_shape.deemphasis_level  <= cfg_regs.deemphasis_level;
			lane1_power         <= (state_q != redriver_pkg::ST_DISABLED);
			lane2_power         <= (state_q != redriver_pkg::ST_DISABLED)
			                       && (lane2_active || state_q == redriver_pkg::ST_DISC);
		end
	end
endmodule
`default_nettype wire

/* verification/redriver_ctrl_asserts.sv */
// assertions for the redriver control block
`timescale 1ns/1ps
`default_nettype none
module redriver_ctrl_asserts #(
	parameter int unsigned RXDET_CYC = 50,
	parameter int unsigned WAKE_CYC  = 8
) (
	// clock, reset and inputs
	input wire logic                     ref_clk,
	input wire logic                     rst_n,
	input wire logic                     enable,
	input wire redriver_pkg::cfg_regs_s  cfg_regs,
	input wire logic [2:0]               link_state,
	input wire logic                     idle_break,
	input wire logic                     lane2_active,
	// outputs
	input wire logic                     strap_pulls_on,
	input wire logic                     tx_idle,
	input wire logic                     lfps_forward,
	input wire logic                     rx_detect_pulse,
	input wire logic                     lane1_power,
	input wire logic                     lane2_power,
	input wire logic [1:0]               connector_eq_mode,
	input wire logic                     eq_settled,
	input wire logic                     host_to_conn_linear,
	input wire redriver_pkg::tx_shape_s  host_side_tx_shape,
	input wire redriver_pkg::pwr_state_e power_state
);
	int unsigned gap_q;
	int unsigned wake_q;
	int unsigned settle_q;

	// cycles since the last detection pulse while disconnected
	always_ff @(posedge ref_clk or negedge rst_n)
		if (!rst_n)
			gap_q <= 0;
		else if (rx_detect_pulse || power_state != redriver_pkg::ST_DISC)
			gap_q <= 0;
		else
			gap_q <= gap_q + 1;

	// cycles spent waking
	always_ff @(posedge ref_clk or negedge rst_n)
		if (!rst_n)
			wake_q <= 0;
		else
			wake_q <= (power_state == redriver_pkg::ST_WAKE) ? wake_q + 1 : 0;

	// cycles in U0 before equalization settles
	always_ff @(posedge ref_clk or negedge rst_n)
		if (!rst_n)
			settle_q <= 0;
		else
			settle_q <= (power_state == redriver_pkg::ST_U0 && !eq_settled) ? settle_q + 1 : 0;

	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_n);

	sequence s_u1_break;
		power_state == redriver_pkg::ST_U1 && idle_break && enable && !lfps_forward;
	endsequence
	sequence s_lfps_on;
		lfps_forward && !tx_idle;
	endsequence

	AST_IDLE_ENTRY: assert property (power_state == redriver_pkg::ST_U0 && link_state != 3'h0 && enable |=> tx_idle)
		else $error("idle entry late");
	AST_U1_EXIT: assert property (s_u1_break |=> s_lfps_on)
		else $error("u1 exit late");
	AST_WAKE_BOUND: assert property (wake_q <= WAKE_CYC + 2)
		else $error("wake too long");
	AST_RXDET: assert property (power_state == redriver_pkg::ST_DISC |-> gap_q <= RXDET_CYC)
		else $error("detect interval exceeded");
	AST_FULL_SETTLE: assert property (settle_q <= redriver_pkg::AEQ_FULL_CYC + 4)
		else $error("full settle late");
	AST_FAST_SETTLE: assert property (connector_eq_mode == redriver_pkg::EQ_FAST |-> settle_q <= redriver_pkg::AEQ_FAST_CYC + 4)
		else $error("fast settle late");
	AST_LANE_DROP: assert property ((power_state == redriver_pkg::ST_U0 && !lane2_active) [*2] |-> !lane2_power)
		else $error("unused lane powered");
	AST_LINEAR: assert property (host_to_conn_linear)
		else $error("host path not linear");
	AST_LIMITED: assert property (host_side_tx_shape.limited |-> $past(cfg_regs.use_regs && cfg_regs.limited_en))
		else $error("limited without register");
	AST_HOLD: assert property ($rose(enable) |=> strap_pulls_on [*8])
		else $error("pulls dropped early");
	AST_OFF: assert property (!enable |-> ##2 (power_state == redriver_pkg::ST_DISABLED && !lane1_power && !lane2_power))
		else $error("not disabled");
endmodule
`default_nettype wire

/* verification/link_partner.sv */
// far side model: controlling party straps and link monitor
`timescale 1ns/1ps
`default_nettype none
module link_partner #(
	parameter int unsigned EN_LOW_CYC = 20,
	parameter int unsigned SU_CYC     = 10,
	parameter int unsigned HD_CYC     = 14
) (
	// clock
	input  wire logic                 ref_clk,
	// enable and straps
	output var logic                  enable,
	output var redriver_pkg::straps_s straps,
	// link monitor
	output var logic [2:0]            link_state,
	output var logic                  idle_break,
	output var logic                  far_end_present,
	output var logic                  lane2_active,
	output var logic                  gen2_rate,
	output var logic [3:0]            analog_best_lane1,
	output var logic [3:0]            analog_best_lane2,
	output var logic                  long_channel_lane1,
	output var logic                  long_channel_lane2
);
	initial
	begin
		enable = 1'b0;
		straps = '0;
		link_state = redriver_pkg::LINK_DISC;
		{idle_break, far_end_present, gen2_rate} = 3'h0;
		lane2_active = 1'b1;
		set_lanes(1'b1, 1'b0, 4'h0, 1'b0);
	end

	task automatic power_up(input redriver_pkg::straps_s s);
		enable = 1'b0;
		straps = s;
		repeat (EN_LOW_CYC + SU_CYC) @(negedge ref_clk);
		enable = 1'b1;
		repeat (HD_CYC) @(negedge ref_clk);
		straps = ~s;
	endtask

	task automatic power_down;
		enable = 1'b0;
	endtask

	task automatic set_link(input logic [2:0] st, input logic brk, input logic far);
		link_state = st;
		idle_break = brk;
		far_end_present = far;
	endtask

	task automatic set_lanes(input logic l2, input logic g2, input logic [3:0] b, input logic lc);
		lane2_active = l2;
		gen2_rate = g2;
		analog_best_lane1 = b;
		analog_best_lane2 = b + 4'h1;
		long_channel_lane1 = lc;
		long_channel_lane2 = lc;
	endtask
endmodule
`default_nettype wire

/* verification/testbench.sv */
// self-checking bench for the redriver control block
`timescale 1ns/1ps
`default_nettype none
`define CK(n, e, a) begin checks_done++; if ((a) !== (e)) begin mismatches++; $display("MISMATCH %s exp %0h got %0h", n, e, a); end end
`define WAIT(c, n) for (int k = 0; k < (n) && !(c); k++) @(negedge ref_clk);
module testbench;
	localparam int unsigned RXDET = 50;
	localparam int unsigned HOLD  = 10;
	localparam int unsigned WAKE  = 8;
	logic                     ref_clk, rst_n, enable, strap_pulls_on, idle_break, far_end_present;
	logic                     lane2_active, gen2_rate, long_channel_lane1, long_channel_lane2;
	logic                     tx_idle, lfps_forward, rx_detect_pulse, lane1_power, lane2_power;
	logic                     gen2_mode, eq_settled, host_to_conn_linear;
	logic [2:0]               link_state;
	logic [3:0]               analog_best_lane1, analog_best_lane2, connector_eq_lane1, connector_eq_lane2;
	logic [3:0]               host_side_eq_lane1, host_side_eq_lane2;
	logic [1:0]               connector_eq_mode;
	redriver_pkg::straps_s    straps;
	redriver_pkg::cfg_regs_s  cfg_regs;
	redriver_pkg::tx_shape_s  host_side_tx_shape;
	redriver_pkg::pwr_state_e power_state;
	int                       mismatches, checks_done;

	link_partner #(.HD_CYC(HOLD + 4)) i_link_partner (.ref_clk, .enable, .straps, .link_state, .idle_break,
		.far_end_present, .lane2_active, .gen2_rate, .analog_best_lane1, .analog_best_lane2,
		.long_channel_lane1, .long_channel_lane2);
	redriver_ctrl #(.RXDET_CYC(RXDET), .HOLD_CYC(HOLD), .WAKE_CYC(WAKE)) i_redriver_ctrl (.ref_clk, .rst_n,
		.enable, .straps, .strap_pulls_on, .cfg_regs, .link_state, .idle_break, .far_end_present, .lane2_active,
		.gen2_rate, .analog_best_lane1, .analog_best_lane2, .long_channel_lane1, .long_channel_lane2, .tx_idle,
		.lfps_forward, .rx_detect_pulse, .lane1_power, .lane2_power, .gen2_mode, .connector_eq_lane1,
		.connector_eq_lane2, .host_side_eq_lane1, .host_side_eq_lane2, .connector_eq_mode, .eq_settled,
		.host_to_conn_linear, .host_side_tx_shape, .power_state);

	initial
	begin
		ref_clk = 1'b0;
		forever #12.5 ref_clk = ~ref_clk;
	end

	task automatic stop_test;
		$display("checks %0d mismatches %0d", checks_done, mismatches);
		if (mismatches == 0 && checks_done > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	task automatic step(input int n);
		repeat (n) @(negedge ref_clk);
	endtask

	task automatic back_u0;
		i_link_partner.set_link(redriver_pkg::LINK_U0, 1'b0, 1'b1);
		step(4);
		`CK("lfps off", 1'b0, lfps_forward)
	endtask

	task automatic t_strap;
		i_link_partner.power_up({2'h0, 2'h2, 2'h1, 2'h3, 2'h0, 2'h0, 2'h0});
		`CK("pulls", 1'b0, strap_pulls_on)
		`WAIT(power_state == redriver_pkg::ST_DISC, 10)
		`CK("disc", redriver_pkg::ST_DISC, power_state)
	endtask

	task automatic t_disc;
		int n;
		n = 0;
		repeat (2 * RXDET + 2)
		begin
			@(negedge ref_clk);
			n += rx_detect_pulse;
		end
		`CK("rxdet", 1'b1, n >= 2 && n <= 3)
	endtask

	task automatic t_connect(input logic [3:0] ce, input logic [3:0] he, input logic [3:0] ce2, input logic [3:0] he2);
		i_link_partner.set_link(redriver_pkg::LINK_U0, 1'b0, 1'b1);
		`WAIT(power_state == redriver_pkg::ST_U0, 10)
		step(2);
		`WAIT(eq_settled, 20000)
		`CK("u0", redriver_pkg::ST_U0, power_state)
		`CK("idle", 1'b0, tx_idle)
		`CK("ceq", ce, connector_eq_lane1)
		`CK("heq", he, host_side_eq_lane1)
		`CK("ceq2", ce2, connector_eq_lane2)
		`CK("heq2", he2, host_side_eq_lane2)
	endtask

	task automatic t_lanes;
		i_link_partner.set_lanes(1'b0, 1'b1, 4'hb, 1'b1);
		step(3);
		`CK("lane2", 1'b0, lane2_power)
		`CK("lane1", 1'b1, lane1_power)
		`CK("gen2", 1'b1, gen2_mode)
		i_link_partner.set_lanes(1'b1, 1'b0, 4'hb, 1'b1);
		step(3);
		`CK("lane2", 1'b1, lane2_power)
		`CK("gen2", 1'b0, gen2_mode)
	endtask

	task automatic t_u1;
		i_link_partner.set_link(redriver_pkg::LINK_U1, 1'b0, 1'b1);
		step(1);
		`CK("idle", 1'b1, tx_idle)
		step(2);
		i_link_partner.set_link(redriver_pkg::LINK_U1, 1'b1, 1'b1);
		step(1);
		`CK("lfps", 1'b1, lfps_forward)
		`CK("idle", 1'b0, tx_idle)
		back_u0;
	endtask

	task automatic t_wake;
		for (int i = 2; i <= 3; i++)
		begin
			i_link_partner.set_link(3'(i), 1'b0, 1'b1);
			step(3);
			i_link_partner.set_link(3'(i), 1'b1, 1'b1);
			step(WAKE - 2);
			`CK("early", 1'b0, lfps_forward)
			`WAIT(lfps_forward, 8)
			`CK("lfps", 1'b1, lfps_forward)
			back_u0;
		end
	endtask

	task automatic t_aeq;
		logic [3:0] exp [3];
		logic [3:0] exp2 [3];
		exp = '{4'h5, 4'h9, 4'hb};
		exp2 = '{4'h6, 4'h9, 4'hc};
		for (int m = 0; m < 3; m++)
		begin
			i_link_partner.set_link(redriver_pkg::LINK_DISC, 1'b0, 1'b0);
			step(4);
			cfg_regs = '0;
			cfg_regs.use_regs = 1'b1;
			cfg_regs.conn_eq_lane1 = 4'h5;
			cfg_regs.host_eq_lane1 = 4'h7;
			cfg_regs.conn_eq_lane2 = 4'h6;
			cfg_regs.host_eq_lane2 = 4'h8;
			cfg_regs.conn_eq_mode = 2'(m);
			step(2);
			t_connect(exp[m], 4'h7, exp2[m], 4'h8);
			`CK("mode", 2'(m), connector_eq_mode)
		end
	endtask

	task automatic t_limited;
		`CK("lim", 1'b0, host_side_tx_shape.limited)
		for (int l = 0; l < 4; l++)
		begin
			cfg_regs.limited_en = 1'b1;
			cfg_regs.preshoot_enable = 1'b1;
			cfg_regs.preshoot_level = 2'(l);
			cfg_regs.deemphasis_enable = 1'b1;
			cfg_regs.deemphasis_level = 2'(3 - l);
			step(2);
			`CK("shape", {2'h3, 2'(l), 1'b1, 2'(3 - l)}, host_side_tx_shape)
		end
		`CK("h2c", 1'b1, host_to_conn_linear)
	endtask

	task automatic t_disable;
		i_link_partner.power_down();
		step(2);
		`CK("off", redriver_pkg::ST_DISABLED, power_state)
		`CK("lane1", 1'b0, lane1_power)
		`CK("pulls", 1'b1, strap_pulls_on)
	endtask

	initial
	begin
		mismatches = 0;
		checks_done = 0;
		rst_n = 1'b0;
		cfg_regs = '0;
		step(5);
		rst_n = 1'b1;
		`CK("rst idle", 1'b1, tx_idle)
		`CK("rst state", redriver_pkg::ST_DISABLED, power_state)
		t_strap;
		t_disc;
		t_connect(4'h9, 4'hc, 4'h9, 4'hc);
		t_lanes;
		t_u1;
		t_wake;
		t_aeq;
		t_limited;
		t_disable;
		stop_test;
	end

	initial
	begin
		step(40000);
		mismatches++;
		$display("watchdog expired");
		stop_test;
	end
endmodule
bind redriver_ctrl redriver_ctrl_asserts #(.RXDET_CYC(RXDET_CYC), .WAKE_CYC(WAKE_CYC)) i_redriver_ctrl_asserts (
	.ref_clk, .rst_n, .enable, .cfg_regs, .link_state, .idle_break, .lane2_active, .strap_pulls_on, .tx_idle,
	.lfps_forward, .rx_detect_pulse, .lane1_power, .lane2_power, .connector_eq_mode, .eq_settled,
	.host_to_conn_linear, .host_side_tx_shape, .power_state);
`default_nettype wire
